//--- src/spcr_regs.sv
// Behaviour
// - Soft reset with strap high reloads nonvolatile values
// - Soft reset with strap low restores defaults
// - Read-only part identifier at 0x003
// - Bit 0 of readback_bank_select selects readback bank
// - 0x005 holds tag low byte, reset zero
// - 0x006 holds tag high byte, reset zero
`timescale 1ns/10ps
`include "spcr_params.svh"

module spcr_regs (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // Register access port
  input wire spcr_pkg::spcr_addr_t reg_addr,
  input wire logic reg_wr,
  input wire spcr_pkg::spcr_byte_t reg_wdata,
  input wire logic reg_rd,
  output spcr_pkg::spcr_byte_t reg_rdata,
  output logic reg_rvalid,
  // Strap pin and device events
  input wire logic nv_select_pin,
  input wire logic io_update,
  // Nonvolatile image
  input wire spcr_pkg::spcr_tag_t nv_tag,
  input wire logic nv_bank_sel,
  // Status towards the device
  output logic soft_reset_pulse,
  output logic nv_load_req,
  output logic readback_active,
  output spcr_pkg::spcr_tag_t tag_active
);

  function automatic logic hit(input spcr_pkg::spcr_addr_t a, input spcr_pkg::spcr_addr_t off);
    hit = (a == off);
  endfunction

  logic strap_meta_q;
  logic strap_q;
  logic srst_q;
  logic srst_d;
  logic nv_load_q;
  logic nv_load_d;
  logic bank_q;
  logic bank_d;
  spcr_pkg::spcr_tag_t tag_buf_q;
  spcr_pkg::spcr_tag_t tag_buf_d;
  spcr_pkg::spcr_tag_t tag_act_q;
  spcr_pkg::spcr_tag_t tag_act_d;
  spcr_pkg::spcr_byte_t rdata_q;
  spcr_pkg::spcr_byte_t rdata_d;
  logic rvalid_q;

  // Write decode
  wire wr_cfg = reg_wr && hit(reg_addr, `SPCR_OFF_CONFIG);
  wire wr_bank = reg_wr && hit(reg_addr, `SPCR_OFF_BANK_SEL);
  wire wr_low = reg_wr && hit(reg_addr, `SPCR_OFF_TAG_LOW);
  wire wr_high = reg_wr && hit(reg_addr, `SPCR_OFF_TAG_HIGH);
  // Only bit 5 acts; mirror bit 2 is redundant by host convention
  wire srst_req = wr_cfg && reg_wdata[`SPCR_BIT_SOFT_RESET];

  // Reload source chosen by synchronised strap
  wire spcr_pkg::spcr_tag_t reload_tag = strap_q ? nv_tag : `SPCR_RST_TAG;
  wire reload_bank = strap_q ? nv_bank_sel : `SPCR_RST_BANK_SEL;

  // Self-clearing soft reset
  assign srst_d = srst_req && !srst_q;

  // Reload from storage only with strap high
  assign nv_load_d = srst_d && strap_q;

  // Bank select, reload wins over write
  always_comb
  begin
    bank_d = bank_q;
    if (wr_bank)
    begin
      bank_d = reg_wdata[`SPCR_BIT_BANK_SEL];
    end
    if (srst_q)
    begin
      bank_d = reload_bank;
    end
  end

  always_comb
  begin
    tag_buf_d = tag_buf_q;
    if (wr_low)
    begin
      tag_buf_d[7:0] = reg_wdata;
    end
    if (wr_high)
    begin
      tag_buf_d[15:8] = reg_wdata;
    end
    if (srst_q)
    begin
      tag_buf_d = reload_tag;
    end
  end

  // Active tag copy
  always_comb
  begin
    tag_act_d = tag_act_q;
    if (io_update)
    begin
      tag_act_d = tag_buf_q;
    end
    if (srst_q)
    begin
      tag_act_d = reload_tag;
    end
  end

  // Readback, unused bits zero
  wire spcr_pkg::spcr_tag_t tag_view = bank_q ? tag_act_q : tag_buf_q;
  wire spcr_pkg::spcr_byte_t cfg_view = {2'h0, srst_q, 1'h0, 1'h0, srst_q, 2'h0};

  // Readback mux
  always_comb
  begin
    rdata_d = `SPCR_RST_BYTE;
    if (hit(reg_addr, `SPCR_OFF_CONFIG))
    begin
      rdata_d = cfg_view;
    end
    else if (hit(reg_addr, `SPCR_OFF_PART_IDENTIFIER))
    begin
      rdata_d = `SPCR_PART_IDENTIFIER_VALUE;
    end
    else if (hit(reg_addr, `SPCR_OFF_BANK_SEL))
    begin
      rdata_d = {7'h00, bank_q};
    end
    else if (hit(reg_addr, `SPCR_OFF_TAG_LOW))
    begin
      rdata_d = tag_view[7:0];
    end
    else if (hit(reg_addr, `SPCR_OFF_TAG_HIGH))
    begin
      rdata_d = tag_view[15:8];
    end
  end

  // Strap synchroniser
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      strap_meta_q <= 1'h0;
      strap_q <= 1'h0;
    end
    else if (ce)
    begin
      strap_meta_q <= nv_select_pin;
      strap_q <= strap_meta_q;
    end
  end

  // Register state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      srst_q <= 1'h0;
      nv_load_q <= 1'h0;
      bank_q <= `SPCR_RST_BANK_SEL;
      tag_buf_q <= `SPCR_RST_TAG;
      tag_act_q <= `SPCR_RST_TAG;
    end
    else if (ce)
    begin
      srst_q <= srst_d;
      nv_load_q <= nv_load_d;
      bank_q <= bank_d;
      tag_buf_q <= tag_buf_d;
      tag_act_q <= tag_act_d;
    end
  end

  // Read valid
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rvalid_q <= 1'h0;
    end
    else if (ce)
    begin
      rvalid_q <= reg_rd;
    end
  end

  // Read data, held until next read
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rdata_q <= `SPCR_RST_BYTE;
    end
    else if (ce && reg_rd)
    begin
      rdata_q <= rdata_d;
    end
  end

  // Status outputs
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign soft_reset_pulse = srst_q;
  assign nv_load_req = nv_load_q;
  assign readback_active = bank_q;
  assign tag_active = tag_act_q;

endmodule

//--- src/spcr_params.svh
`ifndef SPCR_PARAMS_SVH
`define SPCR_PARAMS_SVH

`define SPCR_ADDR_W 12
`define SPCR_OFF_CONFIG 12'h000
`define SPCR_OFF_PART_IDENTIFIER 12'h003
`define SPCR_OFF_BANK_SEL 12'h004
`define SPCR_OFF_TAG_LOW 12'h005
`define SPCR_OFF_TAG_HIGH 12'h006
`define SPCR_BIT_SOFT_RESET 5
`define SPCR_BIT_SOFT_RESET_MIRROR 2
`define SPCR_BIT_BANK_SEL 0
`define SPCR_RST_BANK_SEL 1'h0
`define SPCR_RST_TAG 16'h0000
`define SPCR_RST_BYTE 8'h00
// Arbitrary neutral identifier value
`define SPCR_PART_IDENTIFIER_VALUE 8'h5A

`endif

//--- src/spcr_pkg.sv
package spcr_pkg;
  typedef logic [7:0] spcr_byte_t;
  typedef logic [11:0] spcr_addr_t;
  typedef logic [15:0] spcr_tag_t;
endpackage

//--- tb/spcr_regs_sva.sv
`timescale 1ns/10ps
module spcr_sva (
  input wire logic clk_sys, rst_b, ce, reg_wr, reg_rd, reg_rvalid,
  input wire logic soft_reset_pulse, nv_load_req,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire rd = ce && reg_rd;
  sequence s_sr;
    ce && reg_wr && reg_addr == 12'h000 && reg_wdata[5] && !soft_reset_pulse;
  endsequence
  property p_rv; rd |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no read valid");
  property p_rv0; !rd |=> !reg_rvalid; endproperty
  a_rv0: assert property (p_rv0) else $error("stray valid");
  property p_id; rd && reg_addr == 12'h003 |=> reg_rdata == 8'h5A; endproperty
  a_id: assert property (p_id) else $error("bad part_identifier");
  property p_sr; s_sr |=> soft_reset_pulse ##1 !soft_reset_pulse; endproperty
  a_sr: assert property (p_sr) else $error("soft reset pulse");
  property p_nv; nv_load_req |-> soft_reset_pulse; endproperty
  a_nv: assert property (p_nv) else $error("load without reset");
  property p_c0; rd && reg_addr == 12'h000 |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[4];
  endproperty
  a_c0: assert property (p_c0) else $error("config unused bits");
  property p_bk; rd && reg_addr == 12'h004 |=> reg_rdata[7:1] == 7'h00; endproperty
  a_bk: assert property (p_bk) else $error("bank unused bits");
  property p_un; rd && reg_addr == 12'h007 |=> reg_rdata == 8'h00; endproperty
  a_un: assert property (p_un) else $error("unmapped read");
endmodule
bind spcr_regs spcr_sva i_spcr_sva (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
  .soft_reset_pulse(soft_reset_pulse), .nv_load_req(nv_load_req),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

//--- tb/spcr_host.sv
`timescale 1ns/10ps
module spcr_host (
  input wire logic clk_sys,
  output logic [11:0] reg_addr,
  output logic reg_wr, reg_rd,
  output logic [7:0] reg_wdata
);
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
  // One access, bus inverted after release
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {reg_addr, reg_wr, reg_rd, reg_wdata} = {a, w, !w, d};
    @(negedge clk_sys);
    {reg_addr, reg_wr, reg_rd, reg_wdata} = {~a, 2'h0, ~d};
  endtask
endmodule

//--- tb/serial_port_config_regs_tb_top.sv
`timescale 1ns/10ps
module serial_port_config_regs_tb_top;
  logic clk_sys = 0, rst_b = 0, strap = 1, rv, srp, nlr, rba;
  logic ce = 1, iou = 0;
  logic [11:0] ad;
  logic wr, rdq;
  logic [7:0] wd, rdat;
  logic [15:0] ta;
  int err_count = 0, check_count = 0;
  logic [27:0] rows [6] = '{{12'h005, 8'hAB, 8'hAB}, {12'h006, 8'hCD, 8'hCD},
    {12'h003, 8'hFF, 8'h5A}, {12'h000, 8'hDB, 8'h00}, {12'h004, 8'hFF, 8'h01},
    {12'h007, 8'h33, 8'h00}};
  initial forever #12.5 clk_sys = ~clk_sys;
  spcr_host i_spcr_host (.clk_sys(clk_sys), .reg_addr(ad), .reg_wr(wr), .reg_rd(rdq),
    .reg_wdata(wd));
  spcr_regs i_spcr_regs (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .reg_addr(ad),
    .reg_wr(wr), .reg_wdata(wd), .reg_rd(rdq), .reg_rdata(rdat), .reg_rvalid(rv),
    .nv_select_pin(strap), .io_update(iou), .nv_tag(16'h1234), .nv_bank_sel(1'b1),
    .soft_reset_pulse(srp), .nv_load_req(nlr), .readback_active(rba), .tag_active(ta));
  task chk(input logic [15:0] g, e);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    i_spcr_host.acc(0, a, 8'h00);
    chk({7'h00, rv, rdat}, {8'h01, e});
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys);
    rst_b = 1;
    chk({srp, nlr, rba, ta[12:0]}, 16'h0000);
    foreach (rows[i])
    begin
      i_spcr_host.acc(1, rows[i][27:16], rows[i][15:8]);
      rd(rows[i][27:16], rows[i][7:0]);
    end
    $display("register rows done");
    i_spcr_host.acc(1, 12'h000, 8'h24);
    chk({14'h0000, srp, nlr}, 16'h0003);
    rd(12'h005, 8'h34);
    chk({15'h0000, rba}, 16'h0001);
    chk(ta, 16'h1234);
    strap = 0;
    repeat (3) @(negedge clk_sys);
    i_spcr_host.acc(1, 12'h000, 8'h24);
    chk({14'h0000, srp, nlr}, 16'h0002);
    rd(12'h006, 8'h00);
    chk(ta, 16'h0000);
    $display("soft reset tests done");
    i_spcr_host.acc(1, 12'h005, 8'h77);
    iou = 1;
    @(negedge clk_sys);
    iou = 0;
    chk(ta, 16'h0077);
    ce = 0;
    i_spcr_host.acc(1, 12'h005, 8'h11);
    ce = 1;
    rd(12'h005, 8'h77);
    i_spcr_host.acc(1, 12'h004, 8'h01);
    i_spcr_host.acc(1, 12'h005, 8'h99);
    rd(12'h005, 8'h77);
    rst_b = 0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1;
    chk({srp, nlr, rba, ta[12:0]}, 16'h0000);
    rd(12'h005, 8'h00);
    $display("enable and reset tests done");
    close_out;
  end
  initial
  begin
    repeat (2000) @(posedge clk_sys);
    err_count++;
    close_out;
  end
endmodule
